//--- verilog/ssmon_pkg.sv
package ssmon_pkg;
    // ==========================================================
    // Widths and limits
    localparam int SPD_W      = 16;
    localparam int RESP_W     = 3;
    localparam int NUM_LIM    = 4;
    localparam logic [15:0] SCALE_FULL = 16'h7FFF;
    localparam logic [7:0]  PCT_FULL   = 8'h64;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_LIM0   = 8'h04;
    localparam logic [7:0] OFS_DELAY  = 8'h14;
    localparam logic [7:0] OFS_RESP   = 8'h18;
    localparam logic [7:0] OFS_SCALE  = 8'h1C;
    localparam logic [7:0] OFS_WEIGHT = 8'h20;
    localparam logic [7:0] OFS_GEAR   = 8'h24;
    localparam logic [7:0] OFS_PITCH  = 8'h28;
    localparam logic [7:0] OFS_THR    = 8'h2C;
    localparam logic [7:0] OFS_FILT   = 8'h30;
    localparam logic [7:0] OFS_STAT   = 8'h34;
    localparam logic [7:0] OFS_SETP   = 8'h38;
    // ==========================================================
    // Control register field positions
    localparam int B_LIM_SEL  = 0;
    localparam int B_LSEL_LO  = 1;
    localparam int B_LSEL_HI  = 2;
    localparam int B_BELOW_SEL = 3;
    localparam int B_DIR_POS  = 4;
    localparam int B_DIR_NEG  = 5;
    localparam int B_SCALE_EN = 6;
    localparam int B_TELE_SEL = 7;
    localparam int B_PWRUP    = 8;
    localparam int B_LINEAR   = 9;
    localparam int CTRL_W     = 10;
    // Stop response field of the direction guard
    localparam int RESP_DIR   = 12;
    // ==========================================================
    // Status carried to the controller
    typedef struct packed {
        logic              limit_active_flag;
        logic              limit_level_high_bit;
        logic              limit_level_low_bit;
        logic              speed_below_flag;
        logic              speed_message;
        logic              stop_req;
        logic [RESP_W-1:0] stop_code;
    } ssmon_status_t;
    // Setpoint limits toward the controller, motor side
    typedef struct packed {
        logic signed [SPD_W-1:0] pos;
        logic signed [SPD_W-1:0] neg;
    } ssmon_setp_t;
endpackage

//--- verilog/ssmon_top.sv
// Function
// - Four switchable speed limits; a violation of the enforced limit starts its stop.
// - Lower limit or first selection starts delay; old limit stays enforced until expiry.
// - Change to a higher limit takes effect at once, no delay.
// - After the delay, limited-speed-active status is raised.
// - Enforced level reported as two bits: 00 first, 01 second limit.
// - Each limit has its own stop response, chosen by the enforced limit.
// - Deselecting limiting ends all limit supervision.
// - Scaled first limit equals scale field over 32767 times first limit.
// - Scale field valid 1..32767; others trigger the first limit's stop response.
// - Scaling used only with enable bit set and telegram selection.
// - Setpoint limits: +/- limit times weight, on motor side, while limiting.
// - Rotary motor on linear axis uses gear times pitch, otherwise gear alone.
// - Speed-below flag set while speed lies inside both thresholds.
// - Flag starts at 1 when power-up select is 0, at 0 when 1.
// - Above positive threshold clears flag; resets below threshold minus hysteresis.
// - Below negative threshold clears flag; resets above it plus hysteresis.
// - Speed-below excess raises only a message, never a stop.
// - Speed for the flag is smoothed; nonzero filter time delays the flag.
// - Direction guard stops motion in the inhibited direction with its response.
`timescale 1ns/10ps
module ssmon_top #(
    parameter int DLY_W = 24
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Speed sample, one per monitoring cycle
    input  wire logic signed [ssmon_pkg::SPD_W-1:0] speed,
    // Results
    output ssmon_pkg::ssmon_status_t           status,
    output ssmon_pkg::ssmon_setp_t             setpoint_limit_pair
);
    import ssmon_pkg::*;

    typedef enum logic [1:0] {LIM_OFF, LIM_WAIT, LIM_ON} ssmon_lim_t;

    // ==========================================================
    // Configuration registers
    logic [CTRL_W-1:0]  ctrl_reg;
    logic [SPD_W-1:0]   lim_reg [NUM_LIM];
    logic [DLY_W-1:0]   delay_reg;
    logic [15:0]        resp_reg;
    logic [15:0]        scale_reg;
    logic [7:0]         weight_reg;
    logic [15:0]        gear_num_reg;
    logic [15:0]        gear_den_reg;
    logic [15:0]        pitch_reg;
    logic [SPD_W-1:0]   thr_reg;
    logic [SPD_W-1:0]   hys_reg;
    logic [3:0]         filt_reg;

    // ==========================================================
    // APB decode
    wire        wr_en   = psel & penable & pready & pwrite;
    wire        setup   = psel & ~penable;
    wire        lim_hit = (paddr >= OFS_LIM0) && (paddr < OFS_DELAY) && (paddr[1:0] == 2'h0);
    wire [1:0]  lim_ix  = 2'((paddr - OFS_LIM0) >> 2);
    wire        mapped  = lim_hit || (paddr == OFS_CTRL) || (paddr == OFS_DELAY)
                        || (paddr == OFS_RESP) || (paddr == OFS_SCALE) || (paddr == OFS_WEIGHT)
                        || (paddr == OFS_GEAR) || (paddr == OFS_PITCH) || (paddr == OFS_THR)
                        || (paddr == OFS_FILT) || (paddr == OFS_STAT) || (paddr == OFS_SETP);

    // Control fields
    wire        lim_sel  = ctrl_reg[B_LIM_SEL];
    wire [1:0]  sel_ix   = {ctrl_reg[B_LSEL_HI], ctrl_reg[B_LSEL_LO]};
    wire        below_sel = ctrl_reg[B_BELOW_SEL];
    wire        scale_on = ctrl_reg[B_SCALE_EN] & ctrl_reg[B_TELE_SEL];

    // ==========================================================
    // Scaled first limit
    wire [31:0] scale_prod = 32'(scale_reg) * 32'(lim_reg[0]);
    wire [31:0] scale_quot = scale_prod / 32'(SCALE_FULL);
    wire [SPD_W-1:0] lim0_eff = scale_on ? scale_quot[SPD_W-1:0] : lim_reg[0];
    // Zero or the sign bit set lies outside 1..32767
    wire        scale_bad = scale_on && ((scale_reg == 16'h0000) || (scale_reg > SCALE_FULL));

    // ==========================================================
    // Limit state machine registers
    ssmon_lim_t         st_reg, st_next;
    logic [1:0]         enf_reg, enf_next;
    logic [DLY_W-1:0]   tmr_reg, tmr_next;
    logic               prev_reg, prev_next;

    wire [SPD_W-1:0] sel_lim = (sel_ix == 2'h0) ? lim0_eff : lim_reg[sel_ix];
    wire [SPD_W-1:0] enf_lim = (enf_reg == 2'h0) ? lim0_eff : lim_reg[enf_reg];
    wire             going_up = sel_lim >= enf_lim;

    // Next state of the limit selection
    always_comb begin
        st_next   = st_reg;
        enf_next  = enf_reg;
        tmr_next  = tmr_reg;
        prev_next = prev_reg;
        case (st_reg)
            LIM_OFF: begin
                if (lim_sel) begin
                    st_next   = LIM_WAIT;
                    tmr_next  = delay_reg;
                    prev_next = 1'b0;
                end
            end
            LIM_WAIT: begin
                if (!lim_sel) begin
                    st_next = LIM_OFF;
                end else if (prev_reg && going_up) begin
                    st_next  = LIM_ON;
                    enf_next = sel_ix;
                end else if (tmr_reg == '0) begin
                    st_next  = LIM_ON;
                    enf_next = sel_ix;
                end else begin
                    tmr_next = tmr_reg - 1'b1;
                end
            end
            LIM_ON: begin
                if (!lim_sel) begin
                    st_next = LIM_OFF;
                end else if (sel_ix != enf_reg) begin
                    if (going_up) begin
                        enf_next = sel_ix;
                    end else begin
                        st_next   = LIM_WAIT;
                        tmr_next  = delay_reg;
                        prev_next = 1'b1;
                    end
                end
            end
            default: begin
                st_next = LIM_OFF;
            end
        endcase
    end

    // Old limit stays enforced during a downward delay; deselection ends it without a lag
    wire enforcing = lim_sel && ((st_reg == LIM_ON) || ((st_reg == LIM_WAIT) && prev_reg));

    // ==========================================================
    // Violation checks on this cycle's sample
    wire [SPD_W-1:0] spd_abs  = speed[SPD_W-1] ? SPD_W'(-speed) : speed;
    wire             lim_viol = enforcing && (spd_abs > enf_lim);
    wire             scl_viol = lim_sel && (sel_ix == 2'h0) && scale_bad;
    wire             dir_viol = (ctrl_reg[B_DIR_POS] && speed < 0)
                              || (ctrl_reg[B_DIR_NEG] && speed > 0);
    wire [RESP_W-1:0] lim_resp = resp_reg[enf_reg*RESP_W +: RESP_W];
    wire [RESP_W-1:0] stop_code_next = dir_viol ? resp_reg[RESP_DIR +: RESP_W]
                                     : lim_viol ? lim_resp
                                     : scl_viol ? resp_reg[RESP_W-1:0] : '0;

    // ==========================================================
    // Setpoint limits: limit times weight, then load to motor side
    wire [47:0] weighted = 48'(enf_lim) * 48'(weight_reg) / 48'(PCT_FULL);
    wire [47:0] mot_mul  = ctrl_reg[B_LINEAR] ? 48'(gear_den_reg) * 48'(pitch_reg)
                                              : 48'(gear_den_reg);
    wire [63:0] mot_prod = 64'(weighted) * 64'(mot_mul);
    wire [63:0] mot_spd  = (gear_num_reg == 16'h0000) ? '0 : mot_prod / 64'(gear_num_reg);
    // Saturate so the negation never overflows
    wire [SPD_W-1:0] setp_mag = (mot_spd > 64'(SCALE_FULL)) ? SCALE_FULL : mot_spd[SPD_W-1:0];

    // ==========================================================
    // Speed filter for the speed-below flag
    logic signed [SPD_W+3:0] filt_acc_reg;
    wire signed [SPD_W+3:0] spd_ext  = (SPD_W+4)'(speed);
    wire signed [SPD_W+3:0] filt_dif = (spd_ext - filt_acc_reg) >>> filt_reg;
    wire signed [SPD_W+3:0] filt_spd = (filt_reg == 4'h0) ? spd_ext : filt_acc_reg + filt_dif;
    wire signed [SPD_W+3:0] thr_pos  = (SPD_W+4)'(thr_reg);
    wire signed [SPD_W+3:0] hys_ext  = (SPD_W+4)'(hys_reg);

    // Hysteretic flag
    logic below_reg;
    wire  too_high = filt_spd > thr_pos;
    wire  too_low  = filt_spd < -thr_pos;
    wire  back_in  = (filt_spd < thr_pos - hys_ext) && (filt_spd > -thr_pos + hys_ext);
    wire  below_next = !below_sel ? ~ctrl_reg[B_PWRUP]
                     : (too_high || too_low) ? 1'b0
                     : (below_reg || back_in);

    // ==========================================================
    // Register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg     <= '0;
            delay_reg    <= '0;
            resp_reg     <= '0;
            scale_reg    <= SCALE_FULL;
            weight_reg   <= PCT_FULL;
            gear_num_reg <= 16'h0001;
            gear_den_reg <= 16'h0001;
            pitch_reg    <= 16'h0001;
            thr_reg      <= '0;
            hys_reg      <= '0;
            filt_reg     <= '0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTRL:   ctrl_reg   <= pwdata[CTRL_W-1:0];
                OFS_DELAY:  delay_reg  <= pwdata[DLY_W-1:0];
                OFS_RESP:   resp_reg   <= pwdata[15:0];
                OFS_SCALE:  scale_reg  <= pwdata[15:0];
                OFS_WEIGHT: weight_reg <= pwdata[7:0];
                OFS_GEAR: begin
                    gear_num_reg <= pwdata[15:0];
                    gear_den_reg <= pwdata[31:16];
                end
                OFS_PITCH:  pitch_reg  <= pwdata[15:0];
                OFS_THR: begin
                    thr_reg <= pwdata[15:0];
                    hys_reg <= pwdata[31:16];
                end
                OFS_FILT:   filt_reg   <= pwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // Limit values, one writer per entry
    for (genvar i = 0; i < NUM_LIM; i++) begin : g_lim
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lim_reg[i] <= '0;
            end else if (wr_en && lim_hit && lim_ix == 2'(i)) begin
                lim_reg[i] <= pwdata[SPD_W-1:0];
            end
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (lim_hit) begin
            rd_mux = 32'(lim_reg[lim_ix]);
        end else begin
            case (paddr)
                OFS_CTRL:   rd_mux = 32'(ctrl_reg);
                OFS_DELAY:  rd_mux = 32'(delay_reg);
                OFS_RESP:   rd_mux = 32'(resp_reg);
                OFS_SCALE:  rd_mux = 32'(scale_reg);
                OFS_WEIGHT: rd_mux = 32'(weight_reg);
                OFS_GEAR:   rd_mux = {gear_den_reg, gear_num_reg};
                OFS_PITCH:  rd_mux = 32'(pitch_reg);
                OFS_THR:    rd_mux = {hys_reg, thr_reg};
                OFS_FILT:   rd_mux = 32'(filt_reg);
                OFS_STAT:   rd_mux = 32'(status);
                OFS_SETP:   rd_mux = setpoint_limit_pair;
                default:    rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // One wait-free access phase; data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= setup ? rd_mux : prdata;
        end
    end

    // ==========================================================
    // Monitoring state, one step per clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg       <= LIM_OFF;
            enf_reg      <= '0;
            tmr_reg      <= '0;
            prev_reg     <= 1'b0;
            filt_acc_reg <= '0;
            below_reg    <= 1'b1;
        end else begin
            st_reg       <= st_next;
            enf_reg      <= enf_next;
            tmr_reg      <= tmr_next;
            prev_reg     <= prev_next;
            filt_acc_reg <= filt_spd;
            below_reg    <= below_next;
        end
    end

    // Registered outputs toward the controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status              <= '0;
            setpoint_limit_pair <= '0;
        end else begin
            status.limit_active_flag    <= (st_next == LIM_ON);
            status.limit_level_high_bit <= enf_next[1];
            status.limit_level_low_bit  <= enf_next[0];
            status.speed_below_flag     <= below_next;
            status.speed_message        <= below_sel & ~below_next;
            status.stop_req             <= lim_viol | scl_viol | dir_viol;
            status.stop_code            <= stop_code_next;
            if (enforcing) begin
                setpoint_limit_pair.pos <= setp_mag;
                setpoint_limit_pair.neg <= -setp_mag;
            end else begin
                setpoint_limit_pair <= '0;
            end
        end
    end

endmodule

//--- verification/ssmon_properties.sv
`timescale 1ns/10ps
// ==================================================
// Port-level checks of the speed supervisor
module ssmon_properties #(
    parameter int DLY_W = 24
) (
    // Clock and reset
    input wire logic                               pclk,
    input wire logic                               presetn,
    // Register bus
    input wire logic                               psel,
    input wire logic                               penable,
    input wire logic                               pwrite,
    input wire logic [7:0]                         paddr,
    input wire logic [31:0]                        pwdata,
    input wire logic                               pready,
    // Speed and results
    input wire logic signed [ssmon_pkg::SPD_W-1:0] speed,
    input wire ssmon_pkg::ssmon_status_t           status,
    input wire ssmon_pkg::ssmon_setp_t             setpoint_limit_pair
);
    import ssmon_pkg::*;
    logic [CTRL_W-1:0]  ctrl_reg;
    logic [31:0]        thr_reg;
    logic [14:0]        resp_reg;
    logic [3:0]         filt_reg;
    logic [DLY_W-1:0]   dly_reg;
    logic               wr_done;
    logic               below_raw;
    logic               guard_hit;
    logic signed [17:0] lim_hi;
    logic signed [17:0] band;
    // Write decode and flag band; only the unfiltered path has a fixed latency
    assign wr_done   = psel && penable && pwrite && pready;
    assign lim_hi    = $signed({2'b00, thr_reg[15:0]});
    assign band      = lim_hi - $signed({2'b00, thr_reg[31:16]});
    assign below_raw = ctrl_reg[B_BELOW_SEL] && filt_reg == 4'h0;
    assign guard_hit = (ctrl_reg[B_DIR_POS] && speed < 0) || (ctrl_reg[B_DIR_NEG] && speed > 0);
    // Shadow settings, taken at the design's own write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            thr_reg  <= '0;
            resp_reg <= '0;
            filt_reg <= '0;
            dly_reg  <= '0;
        end else if (wr_done) begin
            case (paddr)
                OFS_CTRL:  ctrl_reg <= pwdata[CTRL_W-1:0];
                OFS_THR:   thr_reg <= pwdata;
                OFS_RESP:  resp_reg <= pwdata[14:0];
                OFS_FILT:  filt_reg <= pwdata[3:0];
                OFS_DELAY: dly_reg <= pwdata[DLY_W-1:0];
                default:   ;
            endcase
        end
    end
    // First selection of limiting, then the delayed activation
    sequence sel_start;
        wr_done && paddr == OFS_CTRL && pwdata[B_LIM_SEL] && !ctrl_reg[B_LIM_SEL] && dly_reg > 3 && dly_reg < 31;
    endsequence
    sequence wait_then_on;
        !status.limit_active_flag [*3] ##[1:40] status.limit_active_flag;
    endsequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Stop and flag results appear one edge after the sample that caused them
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("setup cycle not answered");
    setp_mirror_a: assert property (setpoint_limit_pair.neg == -setpoint_limit_pair.pos)
        else $error("negative setpoint limit not mirrored");
    limit_delay_a: assert property (sel_start |=> wait_then_on)
        else $error("limit activation timing wrong");
    no_stop_a: assert property (!ctrl_reg[B_LIM_SEL] && !ctrl_reg[B_DIR_POS] && !ctrl_reg[B_DIR_NEG]
        |=> !status.stop_req) else $error("stop without an active stop source");
    dir_stop_a: assert property (guard_hit |=> status.stop_req && status.stop_code == resp_reg[14:12])
        else $error("direction guard stop missing");
    flag_high_a: assert property (below_raw && speed > lim_hi |=> !status.speed_below_flag)
        else $error("flag kept above positive threshold");
    flag_low_a: assert property (below_raw && speed < -lim_hi |=> !status.speed_below_flag)
        else $error("flag kept below negative threshold");
    flag_inside_a: assert property (below_raw && speed < band && speed > -band |=> status.speed_below_flag)
        else $error("flag not set inside band");
    flag_idle_a: assert property (presetn && !ctrl_reg[B_BELOW_SEL]
        |=> status.speed_below_flag == !$past(ctrl_reg[B_PWRUP])) else $error("idle flag wrong");
endmodule

bind ssmon_top ssmon_properties #(.DLY_W(DLY_W)) ssmon_properties_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .speed, .status, .setpoint_limit_pair
);

//--- verification/ssmon_ctl_model.sv
`timescale 1ns/10ps
// ==================================================
// Controller stand-in: bus master and speed source
module ssmon_ctl_model (
    // Clock
    input  wire logic                          pclk,
    // Register bus
    output logic                               psel,
    output logic                               penable,
    output logic                               pwrite,
    output logic [7:0]                         paddr,
    output logic [31:0]                        pwdata,
    input  wire logic [31:0]                   prdata,
    input  wire logic                          pready,
    input  wire logic                          pslverr,
    // Measured speed
    output logic signed [ssmon_pkg::SPD_W-1:0] speed
);
    import ssmon_pkg::*;
    int bad = 0;
    // Idle bus and motor at rest from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        speed = 16'h0000;
    end
    // One transfer, held until ready; released lines are scrambled so stale values never help
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) bad++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // One new speed sample, driven after the next edge and held; the caller may leave it above a new limit
    task automatic drive_speed(input int v);
        @(posedge pclk);
        speed <= v[SPD_W-1:0];
    endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import ssmon_pkg::*;
    // ==================================================
    // Wiring
    logic                    pclk = 1'b0;
    logic                    presetn = 1'b0;
    logic                    psel, penable, pwrite, pready, pslverr, fl, fm;
    logic [7:0]              paddr;
    logic [31:0]             pwdata, prdata, rdv;
    logic signed [SPD_W-1:0] speed;
    ssmon_status_t           status;
    ssmon_setp_t             setp;
    int                      mismatches = 0;
    int                      n_compared = 0;
    int                      v;
    int                      sv[7] = '{51, 111, 91, 71, -111, -91, -71};
    logic [15:0]             bad_sc[3] = '{16'h0000, 16'h8000, 16'hFFFF};
    // Half period of the 200 MHz clock
    always #2.5 pclk = ~pclk;
    ssmon_top ssmon_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
                           .pslverr, .speed, .status, .setpoint_limit_pair(setp));
    ssmon_ctl_model ctl (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .speed);
    // ==================================================
    // Helpers
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        mismatches += ctl.bad;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ctl.xfer(1'b1, a, d, rdv, fl);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        ctl.xfer(1'b0, a, 32'h0, rdv, fl);
        cmp(rdv, e);
        cmp({31'h0, fl}, {31'h0, err});
    endtask
    task automatic spd(input int s, input int n);
        ctl.drive_speed(s);
        repeat (n) @(posedge pclk);
    endtask
    task automatic stop_is(input logic [3:0] e);
        cmp({28'h0, status.stop_req, status.stop_code}, {28'h0, e});
    endtask
    // Bounded wait for the enforced limit, then one edge so the setpoint and stop follow it; a hang ends the run
    task automatic wait_active;
        int n;
        for (n = 0; n < 64 && status.limit_active_flag !== 1'b1; n++) @(posedge pclk);
        if (n == 64) mismatches++;
        if (n == 64) close_out();
        @(posedge pclk);
    endtask
    // Expected flag for threshold 100 and hysteresis 20
    function automatic logic below_exp(input logic f, input int s);
        if (s > 100 || s < -100) return 1'b0;
        if (s < 80 && s > -80) return 1'b1;
        return f;
    endfunction
    function automatic int setp_of(input int lim, input int w, input int num, input int den, input int pit);
        return lim * w / 100 * den * pit / num;
    endfunction
    // ==================================================
    // Main sequence
    initial begin
        void'($urandom(66676));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp({31'h0, status.speed_below_flag}, 32'h1);
        cmp(setp, 32'h0);
        rd(OFS_SCALE, 32'h7FFF, 1'b0);
        rd(OFS_WEIGHT, 32'h64, 1'b0);
        rd(8'hFC, 32'h0, 1'b1);
        wr(OFS_CTRL, 32'h100);
        repeat (3) @(posedge pclk);
        cmp({31'h0, status.speed_below_flag}, 32'h0);
        wr(OFS_THR, 32'h0014_0064);
        wr(OFS_CTRL, 32'h8);
        for (int i = 0; i < 7; i++) begin
            spd(sv[i], 3);
            cmp({30'h0, status.speed_message, status.speed_below_flag}, {30'h0, i % 3 != 0, i % 3 == 0});
            stop_is(4'h0);
        end
        fm = 1'b1;
        for (int i = 0; i < 40; i++) begin
            v = int'($urandom_range(200, 0)) * 2 - 199;
            spd(v, 3);
            fm = below_exp(fm, v);
            cmp({31'h0, status.speed_below_flag}, {31'h0, fm});
        end
        spd(1, 4);
        wr(OFS_FILT, 32'h3);
        spd(151, 4);
        cmp({31'h0, status.speed_below_flag}, 32'h1);
        repeat (60) @(posedge pclk);
        cmp({31'h0, status.speed_below_flag}, 32'h0);
        wr(OFS_FILT, 32'h0);
        wr(OFS_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) wr(OFS_LIM0 + 8'(4 * i), 32'(100 * (i + 1)));
        wr(OFS_RESP, 32'h58D1);
        wr(OFS_DELAY, 32'hA);
        wr(OFS_CTRL, 32'h3);
        repeat (3) @(posedge pclk);
        cmp({31'h0, status.limit_active_flag}, 32'h0);
        wait_active();
        cmp({30'h0, status.limit_level_high_bit, status.limit_level_low_bit}, 32'h1);
        cmp(setp, 32'h00C8_FF38);
        spd(251, 3);
        stop_is(4'hA);
        spd(151, 3);
        wr(OFS_CTRL, 32'h1);
        repeat (3) @(posedge pclk);
        stop_is(4'h0);
        wait_active();
        cmp({30'h0, status.limit_level_high_bit, status.limit_level_low_bit}, 32'h0);
        stop_is(4'h9);
        wr(OFS_CTRL, 32'h7);
        spd(351, 3);
        cmp({29'h0, status.limit_active_flag, status.limit_level_high_bit, status.limit_level_low_bit}, 32'h7);
        stop_is(4'h0);
        wr(OFS_WEIGHT, 32'h32);
        wr(OFS_GEAR, 32'h0003_0001);
        repeat (3) @(posedge pclk);
        cmp(32'(setp.pos), 32'(setp_of(400, 50, 1, 3, 1)));
        wr(OFS_PITCH, 32'h2);
        wr(OFS_CTRL, 32'h207);
        repeat (3) @(posedge pclk);
        cmp(32'(setp.pos), 32'(setp_of(400, 50, 1, 3, 2)));
        wr(OFS_CTRL, 32'h0);
        spd(501, 3);
        stop_is(4'h0);
        cmp(setp, 32'h0);
        spd(41, 1);
        wr(OFS_SCALE, 32'h3FFF);
        wr(OFS_CTRL, 32'hC1);
        wait_active();
        spd(61, 3);
        stop_is(4'h9);
        spd(41, 3);
        stop_is(4'h0);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_SCALE, {16'h0, bad_sc[i]});
            repeat (3) @(posedge pclk);
            stop_is(4'h9);
        end
        wr(OFS_CTRL, 32'h81);
        repeat (3) @(posedge pclk);
        stop_is(4'h0);
        wr(OFS_CTRL, 32'h10);
        spd(-11, 3);
        stop_is(4'hD);
        wr(OFS_CTRL, 32'h20);
        spd(11, 3);
        stop_is(4'hD);
        spd(-11, 3);
        stop_is(4'h0);
        close_out();
    end
endmodule
